/* hw/rssp_regs.vh */
// Constants of the strobe sequencer port: register offsets, reset values, opcodes, timing.
// Assumes a 250 MHz system clock and a CPU special-function register bus.
// Behaviour
// - CPU reaches sequencer via instruction port plus X, Y, Z, timeout, control registers.
// - Sequencer raises interrupt requests for stop, wait done and interrupt instruction.
// - MAC timer overflow events pace the sequencer program timing.
// - Immediate strobes are forwarded to the radio at once.
// - Some immediate strobes start or stop the sequencer instead; stop also clears memory and write pointer.
// - Program mode fetches and executes stored instructions from instruction memory.
// - Each non-immediate port write while idle stores a byte into memory; port reads 0xc0 after reset.
// - Port read returns the opcode currently executing, not last written.
// - 24-byte memory, write pointer cleared by reset, saturates at last location.
// - Memory resets to no-op 0xc0; undefined opcodes act as no-op.
// - Run starts on start strobe; ends at last location, stop, or timeout zero.
// - Fetch and execute run at clk_sys divided by DIV, about 8 MHz only with the 250 MHz clock.
`ifndef RSSP_REGS_VH
`define RSSP_REGS_VH
`define RSSP_ADDR_PORT     8'he1
`define RSSP_ADDR_X        8'h00
`define RSSP_ADDR_Y        8'h01
`define RSSP_ADDR_Z        8'h02
`define RSSP_ADDR_T        8'h03
`define RSSP_ADDR_CTRL     8'h04
`define RSSP_RST_PORT      8'hc0
`define RSSP_RST_T         8'hff
`define RSSP_OP_NOP        8'hc0
`define RSSP_OP_STOP       8'hdf
`define RSSP_OP_IMMEDIATE_START_STROBE    8'hfe
`define RSSP_OP_IMMEDIATE_STOP_STROBE     8'hff
`define RSSP_OP_INT        8'hb9
`define RSSP_OP_INCY       8'hbd
`define RSSP_OP_LABEL      8'hba
`define RSSP_OP_WAITX      8'hbb
`define RSSP_T_NOSTOP      8'hff
`define RSSP_SYS_MHZ       250
`define RSSP_SEQ_MHZ       8
`define RSSP_DIV           (`RSSP_SYS_MHZ / `RSSP_SEQ_MHZ)
`endif

/* hw/rssp_seq.v */
// Strobe sequencer: instruction port, data registers, program engine, radio strobes.
// Assumes the CPU register bus and MAC timer overflow pulse are on clk_sys.
`timescale 1ns/1ps
`include "rssp_regs.vh"
module rssp_seq #(
  parameter DEPTH = 24,
  parameter DIV   = `RSSP_DIV
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  // Special-function register bus
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  // Radio register bus
  input  wire [7:0] rf_addr,
  input  wire       rf_wr,
  input  wire [7:0] rf_wdata,
  output reg  [7:0] rf_rdata,
  // MAC timer
  input  wire       mac_ovf,
  // Radio strobes
  output reg        strobe_valid,
  output reg  [7:0] strobe_code,
  // Interrupt requests
  output reg        irq_stop,
  output reg        irq_wait,
  output reg        irq_int,
  // Status
  output wire       running
);
  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_WAIT = 3'b100;

  reg [7:0] mem [0:DEPTH-1];
  reg [4:0] wptr;
  reg [4:0] pc;
  reg [4:0] loop_pc;
  reg [2:0] state;
  reg [7:0] cur_op;
  reg [7:0] x_reg;
  reg [7:0] y_reg;
  reg [7:0] z_reg;
  reg [7:0] t_reg;
  reg [7:0] ctrl;
  reg [5:0] wait_cnt;
  reg       ovf_seen;
  wire      tick;
  integer   i;

  wire port_wr  = sfr_wr && (sfr_addr == `RSSP_ADDR_PORT);
  wire is_imm   = sfr_wdata[7:6] == 2'b11 && sfr_wdata[5:4] == 2'b11;
  wire op_start = port_wr && sfr_wdata == `RSSP_OP_IMMEDIATE_START_STROBE;
  wire op_halt  = port_wr && sfr_wdata == `RSSP_OP_IMMEDIATE_STOP_STROBE;
  wire [7:0] fetch = mem[pc];

  // Enable pulse at the sequencer rate
  rssp_tick #(.DIV(DIV)) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tick    (tick)
  );

  assign running = (state != S_IDLE);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= `RSSP_OP_NOP;
      wptr         <= 5'd0;
      pc           <= 5'd0;
      loop_pc      <= 5'd0;
      state        <= S_IDLE;
      cur_op       <= `RSSP_RST_PORT;
      x_reg        <= 8'h00;
      y_reg        <= 8'h00;
      z_reg        <= 8'h00;
      t_reg        <= `RSSP_RST_T;
      ctrl         <= 8'h00;
      wait_cnt     <= 6'd0;
      ovf_seen     <= 1'b0;
      strobe_valid <= 1'b0;
      strobe_code  <= 8'h00;
      irq_stop     <= 1'b0;
      irq_wait     <= 1'b0;
      irq_int      <= 1'b0;
    end else begin
      strobe_valid <= 1'b0;
      irq_stop     <= 1'b0;
      irq_wait     <= 1'b0;
      irq_int      <= 1'b0;
      if (mac_ovf)
        ovf_seen <= 1'b1;
      // Radio-space data registers
      if (rf_wr) begin
        case (rf_addr)
          `RSSP_ADDR_X:    x_reg <= rf_wdata;
          `RSSP_ADDR_Y:    y_reg <= rf_wdata;
          `RSSP_ADDR_Z:    z_reg <= rf_wdata;
          `RSSP_ADDR_T:    t_reg <= rf_wdata;
          `RSSP_ADDR_CTRL: ctrl  <= rf_wdata;
          default: ;
        endcase
      end
      if (port_wr) begin
        if (op_start) begin
          if (state == S_IDLE) begin
            state   <= S_RUN;
            pc      <= 5'd0;
            loop_pc <= 5'd0;
          end
        end else if (op_halt) begin
          state    <= S_IDLE;
          wptr     <= 5'd0;
          // Stopping by strobe wipes the stored program
          for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= `RSSP_OP_NOP;
          cur_op   <= `RSSP_OP_NOP;
          if (state != S_IDLE)
            irq_stop <= 1'b1;
        end else if (is_imm) begin
          strobe_valid <= 1'b1;
          strobe_code  <= sfr_wdata;
        end else if (state == S_IDLE) begin
          mem[wptr] <= sfr_wdata;
          if (wptr != DEPTH[4:0] - 5'd1)
            wptr <= wptr + 5'd1;
        end
      end else if (tick) begin
        ovf_seen <= mac_ovf;
        if (ovf_seen && state != S_IDLE && t_reg != `RSSP_T_NOSTOP && t_reg != 8'h00)
          t_reg <= t_reg - 8'h01;
        case (state)
          S_IDLE: ;
          S_RUN: begin
            if (t_reg == 8'h00) begin
              state    <= S_IDLE;
              irq_stop <= 1'b1;
              cur_op   <= `RSSP_OP_NOP;
            end else begin
              cur_op <= fetch;
              pc     <= pc + 5'd1;
              if (fetch == `RSSP_OP_STOP) begin
                state    <= S_IDLE;
                wptr     <= 5'd0;
                irq_stop <= 1'b1;
                // A stop instruction also wipes the stored program
                for (i = 0; i < DEPTH; i = i + 1)
                  mem[i] <= `RSSP_OP_NOP;
              end else if (fetch[7:5] == 3'b100) begin
                wait_cnt <= (fetch[4:0] == 5'd0) ? 6'd32 : {1'b0, fetch[4:0]};
                state    <= S_WAIT;
              end else if (fetch == `RSSP_OP_INT) begin
                irq_int <= 1'b1;
              end else if (fetch == `RSSP_OP_INCY) begin
                y_reg <= y_reg + 8'h01;
              end else if (fetch == `RSSP_OP_LABEL) begin
                loop_pc <= pc + 5'd1;
              end else if (fetch[7:6] == 2'b11 && !(fetch == `RSSP_OP_NOP)) begin
                strobe_valid <= 1'b1;
                strobe_code  <= fetch;
              end
              // Other opcodes fall through as no-op
              if (pc == DEPTH[4:0] - 5'd1 && fetch[7:5] != 3'b100 && fetch != `RSSP_OP_STOP) begin
                state    <= S_IDLE;
                irq_stop <= 1'b1;
              end
            end
          end
          S_WAIT: begin
            if (t_reg == 8'h00) begin
              state    <= S_IDLE;
              irq_stop <= 1'b1;
            end else if (ovf_seen) begin
              if (wait_cnt <= 6'd1) begin
                irq_wait <= 1'b1;
                state    <= (pc == DEPTH[4:0]) ? S_IDLE : S_RUN;
                irq_stop <= (pc == DEPTH[4:0]);
              end
              wait_cnt <= wait_cnt - 6'd1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Read paths
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= `RSSP_RST_PORT;
      rf_rdata  <= 8'h00;
    end else begin
      sfr_rdata <= (state == S_IDLE) ? `RSSP_OP_NOP : cur_op;
      case (rf_addr)
        `RSSP_ADDR_X:    rf_rdata <= x_reg;
        `RSSP_ADDR_Y:    rf_rdata <= y_reg;
        `RSSP_ADDR_Z:    rf_rdata <= z_reg;
        `RSSP_ADDR_T:    rf_rdata <= t_reg;
        `RSSP_ADDR_CTRL: rf_rdata <= {ctrl[7:1], running};
        default:         rf_rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* hw/rssp_tick.v */
// Divider that gives a one-cycle enable at the sequencer rate.
// Assumes a single system clock; DIV is the whole-cycle ratio.
`timescale 1ns/1ps
module rssp_tick #(
  parameter DIV = 31
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rstn,
  // Enable out
  output reg  tick
);
  reg [7:0] cnt;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == DIV[7:0] - 8'h01) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

/* tb/rssp_cpu_model.sv */
// CPU model driving the special-function and radio register buses.
// Assumes one clk_sys; requests change just after a rising edge.
`timescale 1ns/1ps
module rssp_cpu_model (
  // Clock
  input  wire       clk_sys,
  // Buses
  output reg  [7:0] sfr_addr,
  output reg  [7:0] sfr_wdata,
  output reg        sfr_wr,
  output reg  [7:0] rf_addr,
  output reg  [7:0] rf_wdata,
  output reg        rf_wr,
  input  wire [7:0] rf_rdata
);
  initial begin
    {sfr_addr, sfr_wdata, sfr_wr} = 17'h0;
    {rf_addr, rf_wdata, rf_wr} = 17'h0;
  end
  // One-cycle write strobe; data inverted once released
  task wr_sfr(input [7:0] d); begin
    @(posedge clk_sys);
    {sfr_addr, sfr_wdata, sfr_wr} <= {8'he1, d, 1'b1};
    @(posedge clk_sys);
    {sfr_wdata, sfr_wr} <= {~d, 1'b0};
  end endtask
  task wr_rf(input [7:0] a, input [7:0] d); begin
    @(posedge clk_sys);
    {rf_addr, rf_wdata, rf_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    {rf_wdata, rf_wr} <= {~d, 1'b0};
  end endtask
  // Read data is one cycle behind the address
  task rd_rf(input [7:0] a, output [7:0] v); begin
    @(posedge clk_sys);
    rf_addr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    v = rf_rdata;
  end endtask
endmodule

/* tb/rssp_seq_props.sv */
// Checker for the strobe sequencer port.
// Assumes one clk_sys domain with asynchronous rstn.
`timescale 1ns/1ps
module rssp_seq_props (
  input wire       clk_sys, rstn, sfr_wr, running,
  input wire       strobe_valid, irq_stop, irq_wait, irq_int,
  input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, strobe_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire pw  = sfr_wr && sfr_addr == 8'he1;
  wire imm = pw && sfr_wdata >= 8'hf0 && sfr_wdata <= 8'hfd;
  a_imm_fwd:
    assert property (imm |=> strobe_valid && strobe_code == $past(sfr_wdata)) else $error("strobe not forwarded");
  a_start_runs:
    assert property (pw && sfr_wdata == 8'hfe && !running |=> running) else $error("start ignored");
  a_stop_idles:
    assert property (pw && sfr_wdata == 8'hff |=> !running) else $error("stop ignored");
  a_ctl_silent:
    assert property (pw && sfr_wdata >= 8'hfe && !running |=> !strobe_valid) else $error("control strobe leaked");
  a_idle_reads:
    assert property (!running ##1 !running |-> sfr_rdata == 8'hc0) else $error("idle read not c0");
  a_stop_pulse:
    assert property (irq_stop |=> !irq_stop) else $error("stop request not a pulse");
  a_stop_irq:
    assert property ($fell(running) |-> ##[0:2] irq_stop) else $error("no stop request");
  a_strobe_cause:
    assert property (strobe_valid && !running && !$past(running) |-> $past(imm)) else $error("stray strobe");
  a_quiet_idle:
    assert property (!running && !$past(running) && !$past(running, 2) |-> !irq_wait && !irq_int)
      else $error("request while idle");
  c_imm: cover property (imm);
  c_end: cover property ($fell(running));
  c_int: cover property (irq_int);
endmodule
bind rssp_seq rssp_seq_props rssp_seq_props_i (.clk_sys, .rstn, .sfr_wr, .running, .strobe_valid, .irq_stop,
  .irq_wait, .irq_int, .sfr_addr, .sfr_wdata, .sfr_rdata, .strobe_code);

/* tb/test_rssp_seq.sv */
// Testbench for the strobe sequencer port with a CPU model on its buses.
// Assumes the design, the CPU model and the checker are compiled first.
`timescale 1ns/1ps
module test_rssp_seq;
  reg        clk_sys, rstn, mac_ovf, ovf_on, seen_int, seen_stop, seen_wait;
  reg  [5:0] oc;
  reg  [7:0] v, y, mem [0:23];
  reg  [7:0] got [$], exp [$];
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, rf_addr, rf_wdata, rf_rdata, strobe_code;
  wire       sfr_wr, rf_wr, strobe_valid, irq_stop, irq_wait, irq_int, running;
  integer    fail_count, n_compared, seed, i, k, n, ptr;
  rssp_seq rssp_seq_i (.clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rf_addr, .rf_wr,
    .rf_wdata, .rf_rdata, .mac_ovf, .strobe_valid, .strobe_code, .irq_stop, .irq_wait, .irq_int, .running);
  rssp_cpu_model rssp_cpu_model_i (.clk_sys, .sfr_addr, .sfr_wdata, .sfr_wr, .rf_addr, .rf_wdata, .rf_wr,
    .rf_rdata);
  task chk(input [7:0] g, input [7:0] e); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  end endtask
  task print_verdict; begin
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  // Port write mirrored into the memory model with a saturating pointer
  task put(input [7:0] b); begin
    rssp_cpu_model_i.wr_sfr(b);
    if (b == 8'hff) begin
      ptr = 0;
      for (i = 0; i < 24; i = i + 1) mem[i] = 8'hc0;
    end else if (b < 8'hf0) begin
      mem[ptr] = b;
      if (ptr < 23) ptr = ptr + 1;
    end
  end endtask
  // Start the stored program and collect what it issues
  task run; begin
    got = {};
    exp = {};
    {seen_int, seen_stop, seen_wait} = 3'b000;
    for (i = 0; i < 24; i = i + 1) if (mem[i] > 8'hc0 && mem[i] < 8'hf0) exp.push_back(mem[i]);
    rssp_cpu_model_i.wr_sfr(8'hfe);
    n = 0;
    while (n < 1000 && (n < 3 || running === 1'b1)) begin
      @(negedge clk_sys);
      if (strobe_valid === 1'b1) got.push_back(strobe_code);
      seen_int = seen_int | irq_int;
      seen_stop = seen_stop | irq_stop;
      seen_wait = seen_wait | irq_wait;
      v = 8'hc0;
      for (i = 0; i < 24; i = i + 1) if (mem[i] === sfr_rdata) v = sfr_rdata;
      chk(v, sfr_rdata);
      n = n + 1;
    end
    if (n == 1000) begin
      fail_count = fail_count + 1;
      $display("BAD %0t program never ended", $time);
      print_verdict;
    end
    chk(8'(got.size()), 8'(exp.size()));
    foreach (exp[j]) if (j < got.size()) chk(got[j], exp[j]);
    chk({7'h0, seen_stop}, 8'h01);
  end endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    oc <= oc + 6'h01;
    mac_ovf <= ovf_on && oc == 6'h00;
  end
  initial begin
    {rstn, mac_ovf, ovf_on, oc} = 9'h0;
    {seed, fail_count, n_compared, ptr} = {32'he494, 96'h0};
    for (k = 0; k < 24; k = k + 1) mem[k] = 8'hc0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(sfr_rdata, 8'hc0);
    for (k = 8'hf0; k <= 8'hfd; k = k + 1) begin
      rssp_cpu_model_i.wr_sfr(k[7:0]);
      @(negedge clk_sys);
      chk(strobe_valid ? strobe_code : 8'h00, k[7:0]);
    end
    $display("immediate strobes done");
    y = $random(seed);
    rssp_cpu_model_i.wr_rf(8'h01, y);
    ovf_on <= 1'b1;
    put(8'h81);
    put(8'hc9);
    put(8'hb9);
    put(8'hbd);
    run;
    ovf_on <= 1'b0;
    chk({7'h0, seen_int}, 8'h01);
    chk({7'h0, seen_wait}, 8'h01);
    rssp_cpu_model_i.rd_rf(8'h01, v);
    chk(v, y + 8'h01);
    rssp_cpu_model_i.rd_rf(8'h10, v);
    chk(v, 8'h00);
    $display("program run done");
    put(8'hff);
    for (k = 0; k < 25; k = k + 1) put(8'hc1 + 8'($unsigned($random(seed)) % 30));
    run;
    $display("full memory run done");
    put(8'hff);
    rssp_cpu_model_i.wr_rf(8'h03, 8'h02);
    ovf_on <= 1'b1;
    run;
    chk({7'h0, n < 300}, 8'h01);
    ovf_on <= 1'b0;
    $display("timeout run done");
    print_verdict;
  end
endmodule
